// ==== rtl/rpc_rx.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// Cascade receiver with three PWM channels
// ----------------------------------------
module rpc_rx
  import rpc_pkg::*;
#(
  parameter int PWM_PERIOD_CYC_P = PWM_PERIOD_CYC // Shorten for simulation
) (
  input wire logic sys_clk,
  input wire logic nrst,
  rpc_if.dev link,
  input wire logic slow_strap,
  output logic cascade_out,
  output logic red_pwm_out,
  output logic green_pwm_out,
  output logic blue_pwm_out
);

  // ----------------------------------------
  // PWM sizing
  // ----------------------------------------
  localparam int STEP = PWM_PERIOD_CYC_P / PWM_LEVELS; // Cycles per level
  localparam int SW = $clog2(STEP + 1); // Prescaler width
  localparam logic [SW-1:0] STEP_LAST = SW'(STEP - 1);

  // ----------------------------------------
  // Link state
  // ----------------------------------------
  logic din; // Sampled data wire
  logic din_d_r, din_d_nxt; // Previous wire level
  logic [CNT_W-1:0] hi_cnt_r, hi_cnt_nxt; // Cycles since rise
  logic [CNT_W-1:0] lo_cnt_r, lo_cnt_nxt; // Cycles held low
  logic [4:0] bit_cnt_r, bit_cnt_nxt; // Own bits captured
  logic [WORD_BITS-1:0] sr_r, sr_nxt; // Captured word
  logic fwd_r, fwd_nxt; // Own word full
  logic fwd_bit_r, fwd_bit_nxt; // Current bit is passed on
  logic seen_low_r, seen_low_nxt; // Current bit has fallen
  logic dout_r, dout_nxt; // Cascade output level
  logic [CH_BITS-1:0] duty_r [3]; // Latched values, 2 red 1 green 0 blue
  logic [CH_BITS-1:0] duty_nxt [3];
  logic slow_r, slow_nxt; // Slow timing selected

  // ----------------------------------------
  // Edge and timing terms
  // ----------------------------------------
  logic rise; // Wire went high
  logic fall; // Wire went low
  logic gap_hit; // Latch gap reached
  logic bit_val; // Decided bit value
  logic [CNT_W-1:0] thr; // Decision threshold
  logic [CNT_W-1:0] zero_bit_high_time; // Regenerated zero high time
  logic [CNT_W-1:0] one_bit_high_time; // Regenerated one high time

  assign din = link.line;

  // ----------------------------------------
  // PWM state
  // ----------------------------------------
  logic [SW-1:0] step_r, step_nxt; // Prescaler
  logic [CH_BITS-1:0] lvl_r, lvl_nxt; // Level counter
  logic [2:0] pwm_r, pwm_nxt; // Channel outputs

  // Edge detection and mode timing
  always_comb begin
    rise = din & ~din_d_r;
    fall = ~din & din_d_r;
    gap_hit = ~din & (lo_cnt_r == GAP_LAST);
    // Strap tied high picks slow timing
    if (slow_r) begin
      thr = LS_THR_CYC;
      zero_bit_high_time = LS_ZERO_HI_CYC;
      one_bit_high_time = LS_ONE_HI_CYC;
    end else begin
      thr = HS_THR_CYC;
      zero_bit_high_time = HS_ZERO_HI_CYC;
      one_bit_high_time = HS_ONE_HI_CYC;
    end
    // Long high means a one
    bit_val = (hi_cnt_r >= thr);
  end

  // Next state of the link side
  always_comb begin
    din_d_nxt = din;
    slow_nxt = slow_strap;
    sr_nxt = sr_r;
    bit_cnt_nxt = bit_cnt_r;
    fwd_nxt = fwd_r;
    fwd_bit_nxt = fwd_bit_r;
    seen_low_nxt = seen_low_r;
    dout_nxt = dout_r;
    duty_nxt = duty_r;
    // Timebase restarts at each rising edge
    if (rise) begin
      hi_cnt_nxt = '0;
    end else if (hi_cnt_r != '1) begin
      hi_cnt_nxt = hi_cnt_r + 1'b1;
    end else begin
      hi_cnt_nxt = hi_cnt_r;
    end
    // Low time counter, saturating
    if (din) begin
      lo_cnt_nxt = '0;
    end else if (lo_cnt_r != '1) begin
      lo_cnt_nxt = lo_cnt_r + 1'b1;
    end else begin
      lo_cnt_nxt = lo_cnt_r;
    end
    // Bit start: decide whether it is passed on
    if (rise) begin
      fwd_bit_nxt = fwd_r;
      seen_low_nxt = 1'b0;
      dout_nxt = 1'b0;
    end
    // Bit end: capture own bits only
    if (fall) begin
      seen_low_nxt = 1'b1;
      if (!fwd_r && !fwd_bit_r) begin
        sr_nxt = {sr_r[WORD_BITS-2:0], bit_val};
        bit_cnt_nxt = bit_cnt_r + 1'b1;
        if (bit_cnt_r == WORD_MSB) begin
          fwd_nxt = 1'b1;
        end
      end
    end
    // Clean pulse after fixed delay
    if (fwd_bit_r && !rise) begin
      if (hi_cnt_r == FWD_DLY_CYC) begin
        dout_nxt = 1'b1;
      end else if (hi_cnt_r == FWD_DLY_CYC + zero_bit_high_time && (seen_low_r || fall)) begin
        dout_nxt = 1'b0;
      end else if (hi_cnt_r == FWD_DLY_CYC + one_bit_high_time) begin
        dout_nxt = 1'b0;
      end
    end
    // Output low whenever no bit is passed on
    if (!fwd_bit_r) begin
      dout_nxt = 1'b0;
    end
    // Gap: latch a full word and restart the frame
    if (gap_hit) begin
      if (bit_cnt_r == WORD_LEN) begin
        duty_nxt[2] = sr_r[23:16];
        duty_nxt[1] = sr_r[15:8];
        duty_nxt[0] = sr_r[7:0];
      end
      bit_cnt_nxt = '0;
      fwd_nxt = 1'b0;
      fwd_bit_nxt = 1'b0;
      dout_nxt = 1'b0;
    end
    // Synchronous reset from the nrst input
    if (!nrst) begin
      din_d_nxt = 1'b0;
      hi_cnt_nxt = '1;
      lo_cnt_nxt = '0;
      bit_cnt_nxt = '0;
      sr_nxt = '0;
      fwd_nxt = 1'b0;
      fwd_bit_nxt = 1'b0;
      seen_low_nxt = 1'b0;
      dout_nxt = 1'b0;
      duty_nxt = '{default: '0};
      slow_nxt = 1'b0;
    end
  end

  // Link registers
  always_ff @(posedge sys_clk) begin
    din_d_r <= din_d_nxt;
    hi_cnt_r <= hi_cnt_nxt;
    lo_cnt_r <= lo_cnt_nxt;
    bit_cnt_r <= bit_cnt_nxt;
    sr_r <= sr_nxt;
    fwd_r <= fwd_nxt;
    fwd_bit_r <= fwd_bit_nxt;
    seen_low_r <= seen_low_nxt;
    dout_r <= dout_nxt;
    duty_r <= duty_nxt;
    slow_r <= slow_nxt;
  end

  // ----------------------------------------
  // PWM generators
  // ----------------------------------------

  // Shared prescaler and level counter
  always_comb begin
    step_nxt = step_r + 1'b1;
    lvl_nxt = lvl_r;
    // One level step per STEP cycles
    if (step_r == STEP_LAST) begin
      step_nxt = '0;
      lvl_nxt = lvl_r + 1'b1;
    end
    // Compare each channel against the level
    for (int i = 0; i < 3; i++) begin
      pwm_nxt[i] = (lvl_r < duty_r[i]);
    end
    if (!nrst) begin
      step_nxt = '0;
      lvl_nxt = '0;
      pwm_nxt = '0;
    end
  end

  // PWM registers
  always_ff @(posedge sys_clk) begin
    step_r <= step_nxt;
    lvl_r <= lvl_nxt;
    pwm_r <= pwm_nxt;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cascade_out = dout_r;
  assign red_pwm_out = pwm_r[2];
  assign green_pwm_out = pwm_r[1];
  assign blue_pwm_out = pwm_r[0];

endmodule

// ==== rtl/rpc_pkg.sv ====
// How it works
// - Synchronous reset from the nrst pin readies receiver
// - Bit timing restarts on every rising input edge
// - After 24 own bits, forward later bits
// - Cascade output stays low until forwarding
// - Captured word frozen while forwarding
// - Forwarded bits regenerated cleanly, 0.4 us delay
// - PWM values hold until a gap
// - Low over 10 us latches word
// - After gap, capture fresh 24 bits first
// - Sender marks latch with long low gap
// - Word order red, green, blue, MSB first
// - PWM period 4 ms, duty from value
// - Each channel has 256 grey levels
// - Strap high slow 400k, open fast 800k
// - Slow bits 2.5 us, highs 700/1800 ns
// - Fast bits 1.25 us, highs 400/850 ns

package rpc_pkg;

  // ----------------------------------------
  // Clock and widths
  // ----------------------------------------
  localparam int CLK_NS = 10; // System clock period
  localparam int CNT_W = 12; // Timing counter width
  localparam int CH_BITS = 8; // Bits per colour value
  localparam int WORD_BITS = 24; // Bits per pixel word
  localparam int PWM_LEVELS = 256; // Grey levels per channel
  localparam logic [4:0] WORD_LEN = 5'h18; // Bits kept per device
  localparam logic [4:0] WORD_MSB = 5'h17; // Index of first bit sent

  // ----------------------------------------
  // Times in ns
  // ----------------------------------------
  localparam int LS_ZERO_HI_NS = 700; // Slow zero_bit_high_time
  localparam int LS_ONE_HI_NS = 1800; // Slow one_bit_high_time
  localparam int LS_BIT_NS = 2500; // Slow bit period
  localparam int HS_ZERO_HI_NS = 400; // Fast zero_bit_high_time
  localparam int HS_ONE_HI_NS = 850; // Fast one_bit_high_time
  localparam int HS_BIT_NS = 1250; // Fast bit period
  localparam int GAP_MIN_NS = 10000; // Least latch gap
  localparam int GAP_TYP_NS = 24000; // Gap the sender makes
  localparam int FWD_DLY_NS = 400; // Forwarding delay
  localparam int PWM_PERIOD_NS = 4000000; // PWM repetition period

  // ----------------------------------------
  // Times in cycles
  // ----------------------------------------
  localparam logic [CNT_W-1:0] LS_ZERO_HI_CYC = CNT_W'(LS_ZERO_HI_NS / CLK_NS);
  localparam logic [CNT_W-1:0] LS_ONE_HI_CYC = CNT_W'(LS_ONE_HI_NS / CLK_NS);
  localparam logic [CNT_W-1:0] LS_BIT_CYC = CNT_W'(LS_BIT_NS / CLK_NS);
  localparam logic [CNT_W-1:0] HS_ZERO_HI_CYC = CNT_W'(HS_ZERO_HI_NS / CLK_NS);
  localparam logic [CNT_W-1:0] HS_ONE_HI_CYC = CNT_W'(HS_ONE_HI_NS / CLK_NS);
  localparam logic [CNT_W-1:0] HS_BIT_CYC = CNT_W'(HS_BIT_NS / CLK_NS);
  // Midpoint between zero and one high times
  localparam logic [CNT_W-1:0] LS_THR_CYC =
    CNT_W'((LS_ZERO_HI_NS + LS_ONE_HI_NS) / (2 * CLK_NS));
  localparam logic [CNT_W-1:0] HS_THR_CYC =
    CNT_W'((HS_ZERO_HI_NS + HS_ONE_HI_NS) / (2 * CLK_NS));
  // Strictly more than the least gap
  localparam logic [CNT_W-1:0] GAP_CYC = CNT_W'(GAP_MIN_NS / CLK_NS + 1);
  localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(GAP_MIN_NS / CLK_NS);
  localparam logic [CNT_W-1:0] GAP_TX_CYC =
    CNT_W'((GAP_TYP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] FWD_DLY_CYC =
    CNT_W'((FWD_DLY_NS + CLK_NS - 1) / CLK_NS);
  localparam int PWM_PERIOD_CYC = PWM_PERIOD_NS / CLK_NS;

endpackage

// ==== rtl/rpc_if.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// Single data wire between sender and receiver
// ----------------------------------------
interface rpc_if;
  logic line; // Return-to-zero serial data
  modport host (output line);
  modport dev (input line);
endinterface

// ==== rtl/rpc_host.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// Sender for the cascade data wire
// ----------------------------------------
module rpc_host
  import rpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  rpc_if.host link,
  input wire logic slow_mode,
  input wire logic word_valid,
  input wire logic [WORD_BITS-1:0] word_data,
  input wire logic word_last,
  output logic word_ready,
  output logic busy
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [1:0] {
    H_IDLE, // Wire low, waiting
    H_BIT, // Sending one bit
    H_GAP // Sending latch gap
  } rpc_hst_t;

  rpc_hst_t st_r, st_nxt; // Sender state
  logic [CNT_W-1:0] cnt_r, cnt_nxt; // Cycle within bit or gap
  logic [4:0] idx_r, idx_nxt; // Bits left after current
  logic [WORD_BITS-1:0] sh_r, sh_nxt; // Word, MSB first
  logic last_r, last_nxt; // Current word ends frame
  logic line_r, line_nxt; // Wire level
  logic [CNT_W-1:0] thigh; // High time of current bit
  logic [CNT_W-1:0] tbit; // Bit period
  logic bit_end; // Last cycle of a bit
  logic take; // Word accepted

  // Bit shape for the selected speed
  always_comb begin
    if (slow_mode) begin
      tbit = LS_BIT_CYC;
      thigh = sh_r[WORD_BITS-1] ? LS_ONE_HI_CYC : LS_ZERO_HI_CYC;
    end else begin
      tbit = HS_BIT_CYC;
      thigh = sh_r[WORD_BITS-1] ? HS_ONE_HI_CYC : HS_ZERO_HI_CYC;
    end
    bit_end = (st_r == H_BIT) && (cnt_r == tbit - 1'b1);
    // Accept when idle or at the end of a non-final word
    word_ready = (st_r == H_IDLE) || (bit_end && idx_r == '0 && !last_r);
    take = word_ready && word_valid;
  end

  // Next state
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r + 1'b1;
    idx_nxt = idx_r;
    sh_nxt = sh_r;
    last_nxt = last_r;
    line_nxt = line_r;
    unique case (st_r)
      H_IDLE: begin
        cnt_nxt = '0;
        line_nxt = 1'b0;
      end
      // High then low within one period
      H_BIT: begin
        if (cnt_r == thigh - 1'b1) begin
          line_nxt = 1'b0;
        end
        if (bit_end) begin
          cnt_nxt = '0;
          if (idx_r != '0) begin
            idx_nxt = idx_r - 1'b1;
            sh_nxt = {sh_r[WORD_BITS-2:0], 1'b0};
            line_nxt = 1'b1;
          end else if (last_r) begin
            st_nxt = H_GAP;
          end else if (!word_valid) begin
            st_nxt = H_IDLE;
          end
        end
      end
      // Hold low for the latch gap
      H_GAP: begin
        line_nxt = 1'b0;
        if (cnt_r == GAP_TX_CYC - 1'b1) begin
          st_nxt = H_IDLE;
          cnt_nxt = '0;
        end
      end
    endcase
    // Load a new word and start its first bit
    if (take) begin
      st_nxt = H_BIT;
      cnt_nxt = '0;
      idx_nxt = WORD_MSB;
      sh_nxt = word_data;
      last_nxt = word_last;
      line_nxt = 1'b1;
    end
    if (!nrst) begin
      st_nxt = H_IDLE;
      cnt_nxt = '0;
      idx_nxt = '0;
      sh_nxt = '0;
      last_nxt = 1'b0;
      line_nxt = 1'b0;
    end
  end

  // Sender registers
  always_ff @(posedge sys_clk) begin
    st_r <= st_nxt;
    cnt_r <= cnt_nxt;
    idx_r <= idx_nxt;
    sh_r <= sh_nxt;
    last_r <= last_nxt;
    line_r <= line_nxt;
  end

  assign link.line = line_r;
  assign busy = (st_r != H_IDLE);

endmodule

// ==== tb/rpc_chk_sva.sv ====
`timescale 1ns/1ps
// ----
// Checker on the host link
// ----
module rpc_chk #(
  parameter int PWM_PERIOD_CYC_P = 2560 // PWM period in cycles
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic line,
  input wire logic slow_strap,
  input wire logic cascade_out,
  input wire logic red_pwm_out,
  input wire logic green_pwm_out,
  input wire logic blue_pwm_out
);
  localparam int RMAX = PWM_PERIOD_CYC_P - PWM_PERIOD_CYC_P / 256; // Longest high run
  int lh; // Line high run
  int ch; // Cascade high run
  int rc; // Cycles since line rise
  int lc; // Line low run
  int nb; // Falls since gap
  int rr; // Red high run
  logic line_d; // Line last cycle
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Run counters
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      lh <= 0;
      ch <= 0;
      rc <= 9999;
      lc <= 0;
      nb <= 0;
      rr <= 0;
      line_d <= 1'b0;
    end else begin
      lh <= line ? lh + 1 : 0;
      ch <= cascade_out ? ch + 1 : 0;
      rc <= (line && !line_d) ? 1 : (rc < 9999 ? rc + 1 : rc);
      lc <= line ? 0 : (lc < 9999 ? lc + 1 : lc);
      nb <= (lc >= 1000) ? 0 : nb + 32'(!line && line_d);
      rr <= red_pwm_out ? rr + 1 : 0;
      line_d <= line;
    end
  end
  // ----
  // Assertions
  // ----
  AST_RST_QUIET: assert property ($rose(nrst) |->
    !cascade_out && !red_pwm_out && !green_pwm_out && !blue_pwm_out)
    else $error("outputs active after reset");
  AST_HOLD_LOW: assert property (cascade_out |-> nb >= 24)
    else $error("cascade active before own word");
  AST_FWD_DELAY: assert property ($rose(cascade_out) |->
    $past(line, 41) && !$past(line, 44)) else $error("forward delay wrong");
  AST_FWD_WIDTH: assert property ($fell(cascade_out) |-> slow_strap ?
    (ch == 70 || ch == 180) : (ch == 40 || (ch >= 80 && ch <= 85)))
    else $error("forwarded pulse width wrong");
  AST_LINE_HIGH: assert property ($fell(line) |-> slow_strap ?
    (lh == 70 || lh == 180) : (lh == 40 || lh == 85)) else $error("line high wrong");
  AST_BIT_PERIOD: assert property ((line && !line_d) |->
    rc == (slow_strap ? 250 : 125) || rc >= 2400) else $error("bit period wrong");
  AST_GAP_QUIET: assert property (lc >= 300 |-> !cascade_out)
    else $error("cascade active in gap");
  AST_PWM_RUN: assert property (rr <= RMAX)
    else $error("red high too long");
  // Main scenarios
  cover property ($fell(cascade_out));
  cover property ($rose(red_pwm_out));
  cover property (line && !line_d && rc >= 2400);
endmodule

// ==== tb/rgb_pwm_cascade_receiver_test.sv ====
`timescale 1ns/1ps
// ----
// Host, receiver and chained receiver
// ----
module rgb_pwm_cascade_receiver_test;
  typedef struct packed {
    logic slow;
    logic [23:0] w0;
    logic [23:0] w1;
  } rpc_row_t;
  localparam int PER = 2560; // Shortened PWM period
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic slow = 1'b0; // Strap and host mode
  logic valid = 1'b0;
  logic [23:0] data = 24'h0;
  logic last = 1'b0;
  logic inj = 1'b0; // Faulty sender level
  logic inj_en = 1'b0; // Faulty sender owns second link
  logic ready;
  logic busy;
  logic c0; // First receiver cascade
  logic c1; // Second receiver cascade
  logic c1_seen = 1'b0; // Second cascade ever high
  logic [5:0] pwm; // Both receivers, red first
  int n_fail = 0;
  int checks_done = 0;
  logic [11:0] m [6]; // High cycles per output
  rpc_row_t rows [3] = '{'{1'b1, 24'hff0080, 24'h01fe7f},
    '{1'b0, 24'h000000, 24'hffffff}, '{1'b0, 24'h80c301, 24'h7e1a00}};
  rpc_if l0 ();
  rpc_if l1 ();
  assign l1.line = inj_en ? inj : c0;
  always #5 sys_clk = ~sys_clk;
  // Last device never gets more than its own word
  always @(posedge sys_clk) c1_seen <= c1_seen | c1;
  rpc_host u_rpc_host (.sys_clk(sys_clk), .nrst(nrst), .link(l0), .slow_mode(slow),
    .word_valid(valid), .word_data(data), .word_last(last), .word_ready(ready), .busy(busy));
  rpc_rx #(.PWM_PERIOD_CYC_P(PER)) u_rpc_rx (.sys_clk(sys_clk), .nrst(nrst), .link(l0),
    .slow_strap(slow), .cascade_out(c0), .red_pwm_out(pwm[5]), .green_pwm_out(pwm[4]),
    .blue_pwm_out(pwm[3]));
  rpc_rx #(.PWM_PERIOD_CYC_P(PER)) u_rpc_rx_next (.sys_clk(sys_clk), .nrst(nrst),
    .link(l1), .slow_strap(slow), .cascade_out(c1), .red_pwm_out(pwm[2]),
    .green_pwm_out(pwm[1]), .blue_pwm_out(pwm[0]));
  rpc_chk #(.PWM_PERIOD_CYC_P(PER)) u_rpc_chk (.sys_clk(sys_clk), .nrst(nrst),
    .line(l0.line), .slow_strap(slow), .cascade_out(c0), .red_pwm_out(pwm[5]),
    .green_pwm_out(pwm[4]), .blue_pwm_out(pwm[3]));
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %0d expected %0d", $time, got, exp);
    end
  endtask
  // Count high cycles over one PWM period
  task automatic meas();
    m = '{default: 12'h0};
    repeat (PER) begin
      @(negedge sys_clk);
      for (int j = 0; j < 6; j++) m[j] += 12'(pwm[5 - j]);
    end
  endtask
  // Duty of each output from its word byte
  task automatic want(input logic [23:0] w0, input logic [23:0] w1);
    logic [47:0] w;
    w = {w0, w1};
    for (int j = 0; j < 6; j++) chk(m[j], 12'(w[47 - 8 * j -: 8] * PER / 256));
  endtask
  // Offer one word until the host takes it
  task automatic take(input logic [23:0] w, input logic l);
    int n;
    valid <= 1'b1;
    data <= w;
    last <= l;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (!ready && n < 9999);
    if (n >= 9999) begin
      n_fail++;
      $display("[FAIL] %0t host never ready", $time);
    end
    @(posedge sys_clk);
  endtask
  // Wait for the host to finish its gap
  task automatic idle();
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (busy && n < 30000);
    if (n >= 30000) begin
      n_fail++;
      $display("[FAIL] %0t host stuck busy", $time);
    end
    @(posedge sys_clk);
  endtask
  // Fast bits from the faulty sender, MSB first
  task automatic send(input logic [23:0] w, input int nb);
    for (int i = 23; i > 23 - nb; i--) begin
      inj <= 1'b1;
      repeat (w[i] ? 85 : 40) @(posedge sys_clk);
      inj <= 1'b0;
      repeat (w[i] ? 40 : 85) @(posedge sys_clk);
    end
  endtask
  task automatic test_done();
    $display("TB: checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    meas();
    want(24'h0, 24'h0);
    chk(12'(c0), 12'h0);
    $display("TB: reset test done");
    foreach (rows[i]) begin
      @(posedge sys_clk);
      slow <= rows[i].slow;
      repeat (4) @(posedge sys_clk);
      take(rows[i].w0, 1'b0);
      take(rows[i].w1, 1'b1);
      valid <= 1'b0;
      idle();
      meas();
      want(rows[i].w0, rows[i].w1);
      $display("TB: row %0d done", i);
    end
    // Outputs hold while a new frame streams in
    @(posedge sys_clk);
    take(24'h123456, 1'b0);
    meas();
    want(24'h80c301, 24'h7e1a00);
    take(24'hc0ffee, 1'b1);
    valid <= 1'b0;
    idle();
    meas();
    want(24'h123456, 24'hc0ffee);
    $display("TB: hold test done");
    // Low under 10 us inside a word must not latch
    @(posedge sys_clk);
    inj_en <= 1'b1;
    send(24'h5a3cc3, 23);
    repeat (900) @(posedge sys_clk);
    send(24'h800000, 1);
    repeat (1100) @(posedge sys_clk);
    meas();
    want(24'h123456, 24'h5a3cc3);
    chk(12'(c1_seen), 12'h0);
    $display("TB: short gap test done");
    // Reset in mid-run clears latched values
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    meas();
    want(24'h0, 24'h0);
    chk(12'(c0), 12'h0);
    $display("TB: mid-run reset test done");
    test_done();
  end
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end
endmodule
